//--- rtl/scsr_top.v
/*
  Channel status readout: two 40-bit status images (left and right
  sub-frames), a 16-bit read-only register port and field decoding.
  Assumes the bi-phase decoder on mclk_i supplies one strobe per
  sub-frame with the status bit, the side and the block start mark.
*/
`timescale 1ns/100ps
`default_nettype none

`include "scsr_map.vh"

module scsr_top #(
  parameter IMG_W = 40,
  parameter IDX_W = 6
) (
  input  wire                      mclk_i,
  input  wire                      nrst_i,
  // status bit strobes from the decoder
  input  wire                      cs_valid_i,
  input  wire                      cs_right_i,
  input  wire                      cs_block_start_i,
  input  wire                      cs_bit_i,
  // read port of the control interface
  input  wire                      rd_en_i,
  input  wire [`SCSR_ADDR_W-1:0]   rd_addr_i,
  output reg  [`SCSR_DATA_W-1:0]   rd_data_o,
  output reg                       rd_ack_o,
  output reg                       rd_err_o,
  // image refresh pulses
  output wire                      left_update_o,
  output wire                      right_update_o,
  // decoded fields of the image picked by dec_right_i
  input  wire                      dec_right_i,
  output reg  [4:0]                word_length_bits_o,
  output reg                       word_length_rsvd_o,
  output reg                       max_sample_len_flag_o,
  output reg  [1:0]                clock_accuracy_level_o,
  output reg  [1:0]                sample_rate_sel_o,
  output reg                       sample_rate_rsvd_o,
  output reg  [3:0]                channel_number_code_o,
  output reg                       channel_dont_care_o,
  output reg  [3:0]                source_number_code_o,
  output reg                       source_dont_care_o,
  output reg  [7:0]                category_code_o,
  output reg                       status_mode0_o,
  output reg  [2:0]                audio_sampling_code_o,
  output reg                       preemph_5015_o,
  output reg                       audio_sampling_rsvd_o,
  output reg                       copyright_asserted_o,
  output reg                       linear_pcm_o,
  output reg                       consumer_use_o
);

  wire [IMG_W-1:0] left_img;
  wire [IMG_W-1:0] right_img;
  wire             left_valid;
  wire             right_valid;
  wire [IMG_W-1:0] sel_img;

  reg  [`SCSR_DATA_W-1:0] rd_data_d;
  reg                     rd_err_d;

  // fields of the selected image
  wire [2:0] word_length_code;
  wire       max_sample_len_flag;
  wire [1:0] clock_accuracy_code;
  wire [3:0] sample_rate_code;
  wire [3:0] channel_number_code;
  wire [3:0] source_number_code;
  wire [7:0] category_code;
  wire [1:0] status_mode_code;
  wire [2:0] audio_sampling_code;
  wire       copyright_flag;
  wire       nonpcm_flag;
  wire       professional_use_flag;

  // next values of the decoded outputs
  reg  [4:0] wl_bits_d;
  reg        wl_rsvd_d;
  reg  [1:0] clk_level_d;
  reg  [1:0] rate_sel_d;
  reg        rate_rsvd_d;
  reg        preemph_d;
  reg        samp_rsvd_d;

  // steer each strobe to the image of its sub-frame
  assign left_valid  = cs_valid_i & ~cs_right_i;
  assign right_valid = cs_valid_i & cs_right_i;

  scsr_capture #(
    .W  (IMG_W),
    .IW (IDX_W)
  ) u_left (
    .mclk_i        (mclk_i),
    .nrst_i        (nrst_i),
    .bit_valid_i   (left_valid),
    .block_start_i (cs_block_start_i),
    .bit_i         (cs_bit_i),
    .image_o       (left_img),
    .update_o      (left_update_o)
  );

  scsr_capture #(
    .W  (IMG_W),
    .IW (IDX_W)
  ) u_right (
    .mclk_i        (mclk_i),
    .nrst_i        (nrst_i),
    .bit_valid_i   (right_valid),
    .block_start_i (cs_block_start_i),
    .bit_i         (cs_bit_i),
    .image_o       (right_img),
    .update_o      (right_update_o)
  );

  // register read decode, unmapped addresses answer zero with error
  always @*
  begin
    rd_data_d = `SCSR_RD_RST;
    rd_err_d  = 1'b0;
    case (rd_addr_i)
      `SCSR_LEFT_LO:   rd_data_d = left_img[15:0];
      `SCSR_LEFT_MID:  rd_data_d = left_img[31:16];
      `SCSR_LEFT_TOP:  rd_data_d = {`SCSR_RSVD_HI, left_img[39:32]};
      `SCSR_RIGHT_LO:  rd_data_d = right_img[15:0];
      `SCSR_RIGHT_MID: rd_data_d = right_img[31:16];
      // right top byte, upper byte reserved
      `SCSR_RIGHT_TOP: rd_data_d = {`SCSR_RSVD_HI, right_img[39:32]};
      default:         rd_err_d  = 1'b1;
    endcase
  end

  // read answer one clock after the request
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rd_data_o <= `SCSR_RD_RST;
      rd_ack_o  <= 1'b0;
      rd_err_o  <= 1'b0;
    end
    else
    begin
      rd_ack_o <= rd_en_i;
      rd_err_o <= rd_en_i & rd_err_d;
      if (rd_en_i)
      begin
        rd_data_o <= rd_data_d;
      end
    end
  end

  // pick the image whose fields are decoded
  assign sel_img = dec_right_i ? right_img : left_img;

  // undefined top nibble is not decoded
  // field extraction of the selected image
  assign word_length_code    = sel_img[`SCSR_WL_MSB:`SCSR_WL_LSB];
  assign max_sample_len_flag = sel_img[`SCSR_MAXLEN_BIT];
  assign clock_accuracy_code = sel_img[`SCSR_CLKACC_MSB:`SCSR_CLKACC_LSB];
  assign sample_rate_code    = sel_img[`SCSR_RATE_MSB:`SCSR_RATE_LSB];
  assign channel_number_code = sel_img[`SCSR_CHAN_MSB:`SCSR_CHAN_LSB];
  assign source_number_code  = sel_img[`SCSR_SRC_MSB:`SCSR_SRC_LSB];
  assign category_code       = sel_img[`SCSR_CAT_MSB:`SCSR_CAT_LSB];
  assign status_mode_code    = sel_img[`SCSR_MODE_MSB:`SCSR_MODE_LSB];
  assign audio_sampling_code = sel_img[`SCSR_SAMP_MSB:`SCSR_SAMP_LSB];
  assign copyright_flag      = sel_img[`SCSR_COPY_BIT];
  assign nonpcm_flag         = sel_img[`SCSR_NONPCM_BIT];
  assign professional_use_flag = sel_img[`SCSR_PROF_BIT];

  // word length table
  // base length for the 20-bit maximum, four more for 24
  always @*
  begin
    wl_rsvd_d = 1'b0;
    case (word_length_code)
      3'h0:    wl_bits_d = 5'h00;
      3'h1:    wl_bits_d = 5'h10;
      3'h2:    wl_bits_d = 5'h12;
      3'h4:    wl_bits_d = 5'h13;
      3'h5:    wl_bits_d = 5'h14;
      3'h6:    wl_bits_d = 5'h11;
      default:
      begin
        wl_bits_d = 5'h00;
        wl_rsvd_d = 1'b1;
      end
    endcase
    if (max_sample_len_flag && (wl_bits_d != 5'h00))
    begin
      wl_bits_d = wl_bits_d + 5'h04;
    end
  end

  always @*
  begin
    case (clock_accuracy_code)
      2'h0:    clk_level_d = 2'h2;
      2'h1:    clk_level_d = 2'h1;
      2'h2:    clk_level_d = 2'h3;
      default: clk_level_d = 2'h0;
    endcase
  end

  // sampling frequency select
  // 0 is 44.1 kHz, 1 is 48 kHz, 2 is 32 kHz, 3 reserved
  always @*
  begin
    rate_rsvd_d = 1'b0;
    case (sample_rate_code)
      4'h0:    rate_sel_d = 2'h0;
      4'h1:    rate_sel_d = 2'h1;
      4'h2:    rate_sel_d = 2'h2;
      default:
      begin
        rate_sel_d  = 2'h3;
        rate_rsvd_d = 1'b1;
      end
    endcase
  end

  // pre-emphasis meaning only for linear PCM
  always @*
  begin
    preemph_d   = 1'b0;
    samp_rsvd_d = 1'b0;
    if (!nonpcm_flag)
    begin
      case (audio_sampling_code)
        3'h0:    samp_rsvd_d = 1'b0;
        3'h1:    preemph_d   = 1'b1;
        default: samp_rsvd_d = 1'b1;
      endcase
    end
    else
    begin
      samp_rsvd_d = (audio_sampling_code != 3'h0);
    end
  end

  // decoded outputs held in flip-flops
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      word_length_bits_o     <= 5'h00;
      word_length_rsvd_o     <= 1'b0;
      max_sample_len_flag_o  <= 1'b0;
      clock_accuracy_level_o <= 2'h0;
      sample_rate_sel_o      <= 2'h0;
      sample_rate_rsvd_o     <= 1'b0;
      channel_number_code_o  <= 4'h0;
      channel_dont_care_o    <= 1'b0;
      source_number_code_o   <= 4'h0;
      source_dont_care_o     <= 1'b0;
      category_code_o        <= 8'h00;
      status_mode0_o         <= 1'b0;
      audio_sampling_code_o  <= 3'h0;
      preemph_5015_o         <= 1'b0;
      audio_sampling_rsvd_o  <= 1'b0;
      copyright_asserted_o   <= 1'b0;
      linear_pcm_o           <= 1'b0;
      consumer_use_o         <= 1'b0;
    end
    else
    begin
      word_length_bits_o     <= wl_bits_d;
      word_length_rsvd_o     <= wl_rsvd_d;
      max_sample_len_flag_o  <= max_sample_len_flag;
      clock_accuracy_level_o <= clk_level_d;
      sample_rate_sel_o      <= rate_sel_d;
      sample_rate_rsvd_o     <= rate_rsvd_d;
      channel_number_code_o  <= channel_number_code;
      channel_dont_care_o    <= (channel_number_code == 4'h0);
      source_number_code_o   <= source_number_code;
      source_dont_care_o     <= (source_number_code == 4'h0);
      category_code_o        <= category_code;
      status_mode0_o         <= (status_mode_code == 2'h0);
      audio_sampling_code_o  <= audio_sampling_code;
      preemph_5015_o         <= preemph_d;
      audio_sampling_rsvd_o  <= samp_rsvd_d;
      copyright_asserted_o   <= ~copyright_flag;
      linear_pcm_o           <= ~nonpcm_flag;
      consumer_use_o         <= ~professional_use_flag;
    end
  end

endmodule

`default_nettype wire

//--- rtl/scsr_map.vh
/*
  Register offsets, field positions, reset values and sizes of the
  channel status readout block.
  Assumes it is included by its bare name from the rtl/ files.
*/
`ifndef SCSR_MAP_VH
`define SCSR_MAP_VH

// image and read port geometry
`define SCSR_IMG_BITS     40
`define SCSR_ADDR_W       7
`define SCSR_DATA_W       16

// read-only register offsets
`define SCSR_LEFT_LO      7'h5a
`define SCSR_LEFT_MID     7'h5b
`define SCSR_LEFT_TOP     7'h5c
`define SCSR_RIGHT_LO     7'h5d
`define SCSR_RIGHT_MID    7'h5e
`define SCSR_RIGHT_TOP    7'h5f

// reset values
`define SCSR_IMG_RST      40'h00_0000_0000
`define SCSR_RSVD_HI      8'h00
`define SCSR_RD_RST       16'h0000

// field positions inside one 40-bit image
`define SCSR_UNDEF_MSB    39
`define SCSR_UNDEF_LSB    36
`define SCSR_WL_MSB       35
`define SCSR_WL_LSB       33
`define SCSR_MAXLEN_BIT   32
`define SCSR_CLKACC_MSB   29
`define SCSR_CLKACC_LSB   28
`define SCSR_RATE_MSB     27
`define SCSR_RATE_LSB     24
`define SCSR_CHAN_MSB     23
`define SCSR_CHAN_LSB     20
`define SCSR_SRC_MSB      19
`define SCSR_SRC_LSB      16
`define SCSR_CAT_MSB      15
`define SCSR_CAT_LSB      8
`define SCSR_MODE_MSB     7
`define SCSR_MODE_LSB     6
`define SCSR_SAMP_MSB     5
`define SCSR_SAMP_LSB     3
`define SCSR_COPY_BIT     2
`define SCSR_NONPCM_BIT   1
`define SCSR_PROF_BIT     0

`endif

//--- rtl/scsr_capture.v
/*
  One channel status image: gathers the first bits of each status
  block from one sub-frame stream and commits them as a whole.
  Assumes bit strobes come from decoder logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module scsr_capture #(
  parameter W  = 40,
  parameter IW = 6
) (
  input  wire          mclk_i,
  input  wire          nrst_i,
  input  wire          bit_valid_i,
  input  wire          block_start_i,
  input  wire          bit_i,
  output reg  [W-1:0]  image_o,
  output reg           update_o
);

  // index of the last wanted bit, cut to the index width on purpose
  localparam integer  LAST_I = W - 1;
  localparam [IW-1:0] LAST   = LAST_I[IW-1:0];

  reg [W-1:0]  shift_q;
  reg [IW-1:0] idx_q;
  reg          synced_q;

  // collect bits 0..W-1 of each block, then commit the whole image
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      shift_q  <= {W{1'b0}};
      idx_q    <= {IW{1'b0}};
      synced_q <= 1'b0;
      image_o  <= {W{1'b0}};
      update_o <= 1'b0;
    end
    else
    begin
      update_o <= 1'b0;
      if (bit_valid_i)
      begin
        if (block_start_i)
        begin
          shift_q[0] <= bit_i;
          idx_q      <= {{(IW-1){1'b0}}, 1'b1};
          synced_q   <= 1'b1;
        end
        else if (synced_q && (idx_q <= LAST))
        begin
          shift_q[idx_q] <= bit_i;
          idx_q          <= idx_q + {{(IW-1){1'b0}}, 1'b1};
          // last wanted bit: publish the complete image
          if (idx_q == LAST)
          begin
            image_o  <= {bit_i, shift_q[W-2:0]};
            update_o <= 1'b1;
          end
        end
      end
    end
  end

endmodule

`default_nettype wire

//--- bench/scsr_source_model.sv
/*
  Behavioural source of channel status strobes, one per sub-frame.
  Assumes the same clock as the readout block; lines are driven just after the rising edge.
*/
`timescale 1ns/100ps
`default_nettype none

module scsr_source_model (
  input  wire logic mclk_i,
  output var logic  cs_valid_o,
  output var logic  cs_right_o,
  output var logic  cs_start_o,
  output var logic  cs_bit_o
);
  initial {cs_valid_o, cs_right_o, cs_start_o, cs_bit_o} = 4'h0;

  // sends n strobes of one side; strobes past 39 carry junk
  // one side per block
  task automatic send(input logic side, input logic start, input int n, input logic [39:0] img);
    int k;
    for (k = 0; k < n; k++)
    begin
      @(posedge mclk_i);
      cs_valid_o <= 1'b1;
      cs_right_o <= side;
      cs_start_o <= start && (k == 0);
      cs_bit_o   <= (k < 40) ? img[k] : ~img[k-40];
    end
    // idle lines show the inverse, never a stale value
    @(posedge mclk_i);
    cs_valid_o <= 1'b0;
    cs_right_o <= ~side;
    cs_start_o <= 1'b1;
    cs_bit_o   <= ~cs_bit_o;
  endtask
endmodule

`default_nettype wire

//--- bench/scsr_top_assertions.sv
/*
  Concurrent checks on the readout block's ports.
  Assumes binding to scsr_top, one clock domain and an active-low reset.
*/
`timescale 1ns/100ps
`default_nettype none

module scsr_top_assertions (
  input wire logic       mclk_i,
  input wire logic       nrst_i,
  input wire logic       rd_en_i,
  input wire logic [6:0] rd_addr_i,
  input wire logic [15:0] rd_data_o,
  input wire logic       rd_ack_o,
  input wire logic       rd_err_o,
  input wire logic       left_update_o,
  input wire logic [1:0] sample_rate_sel_o,
  input wire logic       sample_rate_rsvd_o,
  input wire logic [3:0] channel_number_code_o,
  input wire logic       channel_dont_care_o,
  input wire logic [3:0] source_number_code_o,
  input wire logic       source_dont_care_o,
  input wire logic       preemph_5015_o,
  input wire logic       linear_pcm_o,
  input wire logic [2:0] audio_sampling_code_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // read requests by kind of address
  sequence s_map; rd_en_i && rd_addr_i >= 7'h5a && rd_addr_i <= 7'h5f; endsequence
  sequence s_unmap; rd_en_i && (rd_addr_i < 7'h5a || rd_addr_i > 7'h5f); endsequence
  sequence s_top; rd_en_i && (rd_addr_i == 7'h5c || rd_addr_i == 7'h5f); endsequence

  a_ack_after_req: assert property (rd_en_i |=> rd_ack_o) else $error("read not acknowledged");
  a_ack_has_req: assert property (rd_ack_o |-> $past(rd_en_i)) else $error("ack without read");
  a_err_unmapped: assert property (s_unmap |=> rd_err_o && rd_data_o == 16'h0000) else $error("unmapped read");
  a_no_err_mapped: assert property (s_map |=> !rd_err_o) else $error("mapped read refused");
  a_top_rsvd_zero: assert property (s_top |=> rd_data_o[15:8] == 8'h00) else $error("top byte set");
  a_data_holds: assert property (!rd_en_i |=> $stable(rd_data_o)) else $error("read data moved");
  a_upd_single: assert property (left_update_o |=> !left_update_o) else $error("update too long");
  a_src_dc_code: assert property ($past(nrst_i) |-> source_dont_care_o == (source_number_code_o == 4'h0)) else $error("source decode");
  a_chan_dc_code: assert property ($past(nrst_i) |-> channel_dont_care_o == (channel_number_code_o == 4'h0)) else $error("channel decode");
  a_rate_rsvd_sel: assert property ($past(nrst_i) |-> sample_rate_rsvd_o == (sample_rate_sel_o == 2'h3)) else $error("rate decode");
  a_preemph_pcm: assert property (preemph_5015_o |-> linear_pcm_o && audio_sampling_code_o == 3'h1) else $error("pre-emphasis decode");
endmodule

bind scsr_top scsr_top_assertions u_chk (.mclk_i, .nrst_i, .rd_en_i, .rd_addr_i, .rd_data_o,
  .rd_ack_o, .rd_err_o, .left_update_o, .sample_rate_sel_o, .sample_rate_rsvd_o,
  .channel_number_code_o, .channel_dont_care_o, .source_number_code_o, .source_dont_care_o,
  .preemph_5015_o, .linear_pcm_o, .audio_sampling_code_o);

`default_nettype wire

//--- bench/spdif_channel_status_readout_tb_top.sv
/*
  Self-checking bench of the channel status readout block.
  Assumes the source model and checker files are compiled before this one.
*/
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[FAIL] %0t got %h exp %h", $time, got, exp); end end

module spdif_channel_status_readout_tb_top;
  logic mclk_i = 1'b0, nrst_i = 1'b0, rd_en_i = 1'b0, dec_right_i = 1'b0;
  logic [6:0] rd_addr_i = 7'h00;
  int error_cnt = 0, comparisons = 0, upd = 0;
  wire logic cs_valid_i, cs_right_i, cs_block_start_i, cs_bit_i, rd_ack_o, rd_err_o;
  wire logic left_update_o, right_update_o, word_length_rsvd_o, max_sample_len_flag_o;
  wire logic sample_rate_rsvd_o, channel_dont_care_o, source_dont_care_o, status_mode0_o;
  wire logic preemph_5015_o, audio_sampling_rsvd_o, copyright_asserted_o, linear_pcm_o;
  wire logic consumer_use_o;
  wire logic [15:0] rd_data_o;
  wire logic [7:0]  category_code_o;
  wire logic [4:0]  word_length_bits_o;
  wire logic [3:0]  channel_number_code_o, source_number_code_o;
  wire logic [2:0]  audio_sampling_code_o;
  wire logic [1:0]  clock_accuracy_level_o, sample_rate_sel_o;
  localparam logic [39:0] LI = 40'h5c_9e31_a7d2, RI = 40'ha3_61ce_582d;

  scsr_source_model u_src (.mclk_i, .cs_valid_o(cs_valid_i), .cs_right_o(cs_right_i),
    .cs_start_o(cs_block_start_i), .cs_bit_o(cs_bit_i));
  scsr_top u_dut (.*);

  initial forever #50 mclk_i = ~mclk_i;
  // counts image commits of both sides
  always @(posedge mclk_i) if (left_update_o === 1'b1 || right_update_o === 1'b1) upd++;

  task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic er);
    @(posedge mclk_i);
    rd_en_i <= 1'b1;
    rd_addr_i <= a;
    @(posedge mclk_i);
    rd_en_i <= 1'b0;
    #1 `CHK({rd_ack_o, rd_err_o, rd_data_o}, {1'b1, er, e})
  endtask

  task automatic blk(input logic s, input logic st, input int n, input logic [39:0] im, input int eu);
    int u0;
    u0 = upd;
    u_src.send(s, st, n, im);
    repeat (3) @(posedge mclk_i);
    `CHK(upd - u0, eu)
  endtask

  function automatic logic [4:0] wl_exp(input logic [2:0] c, input logic m);
    logic [4:0] w;
    case (c)
      3'h1: w = 5'd16;
      3'h2: w = 5'd18;
      3'h4: w = 5'd19;
      3'h5: w = 5'd20;
      3'h6: w = 5'd17;
      default: return 5'd0;
    endcase
    return m ? w + 5'd4 : w;
  endfunction

  task automatic t_reset;
    int k;
    for (k = 0; k < 6; k++) rd(7'h5a + k[6:0], 16'h0000, 1'b0);
    `CHK({clock_accuracy_level_o, status_mode0_o, linear_pcm_o, copyright_asserted_o}, 5'b10111)
    `CHK({consumer_use_o, word_length_bits_o, channel_dont_care_o}, 7'b1000001)
  endtask

  task automatic t_images;
    logic [39:0] im;
    logic [15:0] w;
    int k;
    blk(1'b0, 1'b0, 40, 40'hff_ffff_ffff, 0);
    rd(7'h5a, 16'h0000, 1'b0);
    blk(1'b0, 1'b1, 48, LI, 1);
    blk(1'b1, 1'b1, 40, RI, 1);
    for (k = 0; k < 6; k++)
    begin
      im = (k < 3) ? LI : RI;
      w = 16'(im >> (16 * (k % 3)));
      if (k % 3 == 2) w = w & 16'h00ff;
      rd(7'h5a + k[6:0], w, 1'b0);
    end
    rd(7'h59, 16'h0000, 1'b1);
    rd(7'h60, 16'h0000, 1'b1);
    blk(1'b1, 1'b1, 20, 40'h0, 0);
    rd(7'h5d, RI[15:0], 1'b0);
    `CHK(source_number_code_o, LI[19:16])
  endtask

  task automatic t_decode;
    logic [39:0] im;
    logic [7:0] lv;
    logic b1;
    int i;
    @(posedge mclk_i) dec_right_i <= 1'b1;
    for (i = 0; i < 16; i++)
    begin
      b1 = i[3] ^ i[0];
      lv = 8'h36 >> (2 * i[1:0]);
      im = {4'ha, i[2:0], i[3], 2'b01, i[1:0], i[3:0], i[3:0], i[3:0], 8'h11 * i[3:0],
            i[1:0], i[2:0], i[1], b1, i[2]};
      blk(1'b1, 1'b1, 40, im, 1);
      rd(7'h5f, {8'h00, im[39:32]}, 1'b0);
      `CHK({word_length_bits_o, word_length_rsvd_o, max_sample_len_flag_o}, {wl_exp(i[2:0], i[3]), i[1:0] == 2'b11, i[3]})
      `CHK({clock_accuracy_level_o, sample_rate_sel_o, sample_rate_rsvd_o}, {lv[1:0], i < 3 ? i[1:0] : 2'd3, i > 2})
      `CHK({channel_number_code_o, channel_dont_care_o, source_number_code_o, source_dont_care_o}, {i[3:0], i == 0, i[3:0], i == 0})
      `CHK({category_code_o, status_mode0_o, audio_sampling_code_o}, {8'h11 * i[3:0], i[1:0] == 0, i[2:0]})
      `CHK({preemph_5015_o, audio_sampling_rsvd_o}, {!b1 && i[2:0] == 1, b1 ? i[2:0] != 0 : i[2:0] >= 2})
      `CHK({copyright_asserted_o, linear_pcm_o, consumer_use_o}, {~i[1], ~b1, ~i[2]})
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // main sequence after five cycles of reset
  initial
  begin
    repeat (5) @(posedge mclk_i);
    nrst_i <= 1'b1;
    t_reset;
    t_images;
    t_decode;
    print_verdict;
  end

  // watchdog well beyond the expected run of about 940 cycles
  initial
  begin
    #3000000;
    error_cnt++;
    print_verdict;
  end
endmodule

`default_nettype wire
